/* File: rdsr_cfg.svh */
// Constants for the recirculating dynamic shift register.
`ifndef RDSR_CFG_SVH
`define RDSR_CFG_SVH
`define RDSR_DEPTH        256
`define RDSR_FIFO_DEPTH   4
`define RDSR_CLK_NS       100
`define RDSR_CYCLE_MAX_US 100
`define RDSR_CYCLE_MAX_CY ((`RDSR_CYCLE_MAX_US * 1000) / `RDSR_CLK_NS)
`define RDSR_RST_BIT      1'h0
`endif

/* File: rdsr_ctl_model.sv */
// Behavioural model of the outside logic that drives phases, data and select.
`timescale 1ns/1ns
`include "rdsr_cfg.svh"
module rdsr_ctl_model #(
  parameter int DEPTH = `RDSR_DEPTH
) (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [3:0] word_i,
  input  wire logic       sel_i,
  input  wire logic       mem_i,
  input  wire logic       rdy_i,
  input  wire logic [7:0] addr_i,
  input  wire logic       overlap_i,
  output logic            phase1_n_o,
  output logic            phase2_n_o,
  output logic      [3:0] data_o,
  output logic            select_o,
  output logic            busy_o,
  output logic            pend_o,
  output logic      [7:0] pos_o
);
  logic [3:0] cnt_ff;
  logic       hit;

  initial begin
    phase1_n_o = 1'h1;
    phase2_n_o = 1'h1;
    data_o     = 4'h0;
    select_o   = 1'h0;
    busy_o     = 1'h0;
    pend_o     = 1'h0;
    pos_o      = 8'h0;
    cnt_ff     = 4'h0;
  end

  // address compare against the word that the next shift moves out.
  assign hit = pend_o && (pos_o == addr_i);

  // short cycle, stable inputs.
  // Data and select change only at cycle start, so the sampling window never sees an edge.
  always @(negedge clk_i) begin
    if (!busy_o && go_i) begin
      busy_o     <= 1'h1;
      cnt_ff     <= 4'h0;
      data_o     <= word_i;
      phase1_n_o <= 1'h0;
      // phases overlap only when a fault is asked for on purpose.
      phase2_n_o <= !overlap_i;
      // external data for exactly the one addressed word time.
      select_o   <= mem_i ? hit : sel_i;
      if (mem_i && hit) begin
        pend_o <= 1'h0;
      end
    end else if (busy_o) begin
      cnt_ff <= cnt_ff + 4'h1;
      case (cnt_ff)
        4'h3: phase1_n_o <= 1'h1;
        4'h7: phase2_n_o <= 1'h0;
        4'hb: phase2_n_o <= 1'h1;
        4'hf: begin
          busy_o <= 1'h0;
          // word position moves on once per shift.
          pos_o  <= (pos_o == 8'(DEPTH - 1)) ? 8'h0 : pos_o + 8'h1;
        end
        default: ;
      endcase
    end
    // a one-cycle ready pulse sets the pending flop.
    if (rdy_i) begin
      pend_o <= 1'h1;
    end
  end
endmodule

/* File: rdsr_fifo.sv */
// Small valid/ready FIFO that buffers captured input bits.
`timescale 1ns/1ns
module rdsr_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = mem_ff[rd_ff];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= ptr_inc(wr_ff);
      end
      if (pop) begin
        rd_ff <= ptr_inc(rd_ff);
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_no_overflow : assert property (@(posedge clk_i) disable iff (!nrst_i)
    cnt_ff <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

/* File: rdsr_pkg.sv */
// Types shared by the recirculating dynamic shift register files.
package rdsr_pkg;
  typedef enum logic [1:0] {
    RDSR_IDLE,
    RDSR_PH1,
    RDSR_GAP,
    RDSR_PH2
  } rdsr_phase_type;
endpackage

/* File: rdsr_tb_top.sv */
// Self-checking testbench for the recirculating shift register.
`timescale 1ns/1ns
module rdsr_tb_top;
  localparam int DEPTH = 8;
  localparam int CMAX  = 50;
  localparam int WADDR = 3;
  logic       clk_i  = 1'h0;
  logic       nrst_i = 1'h0;
  logic       go     = 1'h0;
  logic [3:0] word_v = 4'h0;
  logic       sel_v  = 1'h0;
  logic       mem_v  = 1'h0;
  logic       rdy    = 1'h0;
  logic [7:0] addr_v = 8'h0;
  logic       ovl_v  = 1'h0;
  logic       ph1_n;
  logic       ph2_n;
  logic [3:0] dat;
  logic       sel;
  logic       pend;
  logic [7:0] pos;
  logic [3:0] dout;
  logic [3:0] valid;
  logic [3:0] ovl;
  logic [3:0] late;
  logic [7:0] pat    = 8'hb4;
  int         n_errors   = 0;
  int         num_checks = 0;
  int         cyc        = 0;

  initial forever #50 clk_i = ~clk_i;

  rdsr_ctl_model #(.DEPTH(DEPTH)) model (
    .clk_i     (clk_i),
    .go_i      (go),
    .word_i    (word_v),
    .sel_i     (sel_v),
    .mem_i     (mem_v),
    .rdy_i     (rdy),
    .addr_i    (addr_v),
    .overlap_i (ovl_v),
    .phase1_n_o(ph1_n),
    .phase2_n_o(ph2_n),
    .data_o    (dat),
    .select_o  (sel),
    .busy_o    (),
    .pend_o    (pend),
    .pos_o     (pos)
  );

  // four registers on shared phases and select store 4-bit words.
  rdsr_top #(.DEPTH(DEPTH), .CYCLE_MAX(CMAX)) uut [3:0] (
    .clk_i        (clk_i),
    .nrst_i       (nrst_i),
    .phase1_n_i   (ph1_n),
    .phase2_n_i   (ph2_n),
    .data_i       (dat),
    .select_ext_i (sel),
    .data_o       (dout),
    .data_valid_o (valid),
    .overlap_err_o(ovl),
    .cycle_late_o (late)
  );

  task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One full two-phase cycle; valid is looked at inside and after phase two.
  task automatic shift(input logic [3:0] w, input logic s);
    @(negedge clk_i);
    go     <= 1'h1;
    word_v <= w;
    sel_v  <= s;
    @(negedge clk_i);
    go <= 1'h0;
    repeat (13) @(negedge clk_i);
    chk("valid_high", valid, 4'hf);
    repeat (4) @(negedge clk_i);
    chk("valid_low", valid, 4'h0);
  endtask

  task automatic t_reset;
    chk("data_rst", dout, 4'h0);
    chk("ovl_rst", ovl, 4'h0);
    chk("late_rst", late, 4'h0);
  endtask

  // Load a pattern, then recirculate it twice while the data pin carries its inverse.
  task automatic t_fill_recirc;
    for (int i = 0; i < DEPTH; i++) begin
      shift({4{pat[i]}}, 1'h1);
      chk("data_empty", dout, 4'h0);
    end
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < DEPTH; i++) begin
        shift({4{~pat[i]}}, 1'h0);
        chk("data_recirc", dout, {4{pat[i]}});
      end
    end
    for (int i = 0; i < DEPTH; i++) begin
      shift({4{~pat[i]}}, 1'h1);
      chk("data_before", dout, {4{pat[i]}});
    end
    for (int i = 0; i < DEPTH; i++) begin
      shift(4'h0, 1'h0);
      chk("data_after", dout, {4{~pat[i]}});
    end
    chk("ovl_clean", ovl, 4'h0);
  endtask

  // One word goes in through the pending flop and the address compare; the rest stays.
  task automatic t_mem;
    logic [3:0] want;
    mem_v  <= 1'h1;
    addr_v <= 8'(WADDR);
    @(negedge clk_i);
    rdy <= 1'h1;
    @(negedge clk_i);
    rdy <= 1'h0;
    @(negedge clk_i);
    chk("pend_set", {3'h0, pend}, 4'h1);
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < DEPTH; i++) begin
        chk("pos_step", pos[3:0], 4'(i));
        shift(4'h5, 1'h0);
        want = (r == 1 && i == WADDR) ? 4'h5 : {4{~pat[i]}};
        chk("mem_word", dout, want);
      end
    end
    chk("pend_clear", {3'h0, pend}, 4'h0);
    mem_v <= 1'h0;
  endtask

  task automatic t_late;
    chk("late_early", late, 4'h0);
    repeat (CMAX + 20) @(negedge clk_i);
    chk("late_set", late, 4'hf);
  endtask

  // A deliberate overlap must raise the sticky flag in every lane.
  task automatic t_overlap;
    @(negedge clk_i);
    ovl_v <= 1'h1;
    go    <= 1'h1;
    @(negedge clk_i);
    go <= 1'h0;
    repeat (17) @(negedge clk_i);
    ovl_v <= 1'h0;
    chk("ovl_set", ovl, 4'hf);
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    repeat (2) @(negedge clk_i);
    nrst_i <= 1'h1;
    repeat (3) @(negedge clk_i);
    t_reset();
    t_fill_recirc();
    t_mem();
    t_late();
    t_overlap();
    summarize();
  end
endmodule

/* File: rdsr_top.sv */
// Two-phase recirculating dynamic shift register, 256 bits deep.
// What this block does
// - Holds 256 bits in one serial pipeline, moving each bit one place per two-phase cycle.
// - Data and select are sampled as the first phase clock rises, at the end of phase 1.
// - The bit leaving the pipeline is presented on the output while the second phase is low.
// - Select chooses external data or the own output bit as the pipeline input.
`timescale 1ns/1ns
`include "rdsr_cfg.svh"
module rdsr_top #(
  parameter int DEPTH     = `RDSR_DEPTH,
  parameter int CYCLE_MAX = `RDSR_CYCLE_MAX_CY
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic phase1_n_i,
  input  wire logic phase2_n_i,
  input  wire logic data_i,
  input  wire logic select_ext_i,
  output logic      data_o,
  output logic      data_valid_o,
  output logic      overlap_err_o,
  output logic      cycle_late_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int TW = $clog2(CYCLE_MAX + 2);

  // Pins are asynchronous to clk_i, so every one passes two flops first.
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic       ph1_n;
  logic       ph2_n;
  logic       din;
  logic       sel;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_ff <= 4'hf;
      sync2_ff <= 4'hf;
    end else begin
      sync1_ff <= {phase1_n_i, phase2_n_i, data_i, select_ext_i};
      sync2_ff <= sync1_ff;
    end
  end

  assign ph1_n = sync2_ff[3];
  assign ph2_n = sync2_ff[2];
  assign din   = sync2_ff[1];
  assign sel   = sync2_ff[0];

  logic ph1_prev_ff;
  logic ph2_prev_ff;
  logic ph1_rise;
  logic ph2_fall;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph1_prev_ff <= 1'h1;
      ph2_prev_ff <= 1'h1;
    end else begin
      ph1_prev_ff <= ph1_n;
      ph2_prev_ff <= ph2_n;
    end
  end

  assign ph1_rise = ph1_n && !ph1_prev_ff;
  assign ph2_fall = !ph2_n && ph2_prev_ff;

  // Phase tracker: a shift is only counted after phase 1 then phase 2.
  rdsr_pkg::rdsr_phase_type state_ff;
  rdsr_pkg::rdsr_phase_type nxt_state;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      rdsr_pkg::RDSR_IDLE: if (!ph1_n) nxt_state = rdsr_pkg::RDSR_PH1;
      rdsr_pkg::RDSR_PH1:  if (ph1_rise) nxt_state = rdsr_pkg::RDSR_GAP;
      rdsr_pkg::RDSR_GAP:  if (ph2_fall) nxt_state = rdsr_pkg::RDSR_PH2;
      rdsr_pkg::RDSR_PH2:  if (ph2_n) nxt_state = rdsr_pkg::RDSR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= rdsr_pkg::RDSR_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // sample window
  // The value latched at the end of phase 1 is the one held through the window.
  logic       cap_valid;
  logic [1:0] cap_data;
  logic       fifo_ready;
  logic [1:0] fifo_data;
  logic       fifo_valid;
  logic       fifo_pop;

  assign cap_valid = (state_ff == rdsr_pkg::RDSR_PH1) && ph1_rise;
  assign cap_data  = {sel, din};

  // The FIFO decouples sampling from the pipeline advance at phase 2.
  rdsr_fifo #(
    .WIDTH(2),
    .DEPTH(`RDSR_FIFO_DEPTH)
  ) u_fifo (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .in_data_i  (cap_data),
    .in_valid_i (cap_valid),
    .in_ready_o (fifo_ready),
    .out_data_o (fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  logic shift_now;
  assign shift_now = (state_ff == rdsr_pkg::RDSR_GAP) && ph2_fall;
  assign fifo_pop  = shift_now;

  logic [DEPTH-1:0] pipe_ff;
  logic [AW-1:0]    head_ff;
  logic             in_bit;

  assign in_bit = fifo_data[1] ? fifo_data[0] : pipe_ff[head_ff];

  // fixed delay
  // A circular pointer replaces a 256-wide shift, so each bit stays put until written.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pipe_ff <= '0;
      head_ff <= '0;
    end else if (shift_now && fifo_valid) begin
      pipe_ff[head_ff] <= in_bit;
      head_ff          <= (head_ff == AW'(DEPTH - 1)) ? '0 : head_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_o       <= `RDSR_RST_BIT;
      data_valid_o <= 1'h0;
    end else begin
      if (shift_now) begin
        data_o <= pipe_ff[head_ff];
      end
      data_valid_o <= (nxt_state == rdsr_pkg::RDSR_PH2);
    end
  end

  // overlap flag
  // Sticky: dynamic storage is undefined after an overlap, so software must re-load.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      overlap_err_o <= 1'h0;
    end else if (!ph1_n && !ph2_n) begin
      overlap_err_o <= 1'h1;
    end
  end

  logic [TW-1:0] idle_cnt_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_cnt_ff  <= '0;
      cycle_late_o <= 1'h0;
    end else begin
      if (shift_now) begin
        idle_cnt_ff <= '0;
      end else if (idle_cnt_ff != TW'(CYCLE_MAX + 1)) begin
        idle_cnt_ff <= idle_cnt_ff + 1'b1;
      end
      if (idle_cnt_ff == TW'(CYCLE_MAX)) begin
        cycle_late_o <= 1'h1;
      end
    end
  end

  a_head_step : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (shift_now && fifo_valid) |=> head_ff == AW'($past(head_ff) + 1'b1))
    else $error("head did not advance by one");

  a_capture_push : assert property (@(posedge clk_i) disable iff (!nrst_i)
    cap_valid |-> fifo_ready)
    else $error("capture lost, FIFO full");

  a_out_on_ph2 : assert property (@(posedge clk_i) disable iff (!nrst_i)
    shift_now |=> data_o == $past(pipe_ff[head_ff]))
    else $error("output not from pipeline end");

  a_recirc_keep : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (shift_now && fifo_valid && !fifo_data[1]) |=> $stable(pipe_ff))
    else $error("recirculation changed contents");

  a_ext_write : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (shift_now && fifo_valid && fifo_data[1])
      |=> pipe_ff[$past(head_ff)] == $past(fifo_data[0]))
    else $error("external bit not stored");

  a_overlap_flag : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!ph1_n && !ph2_n) |=> overlap_err_o)
    else $error("overlap not flagged");

  a_late_flag : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (idle_cnt_ff == TW'(CYCLE_MAX)) |=> cycle_late_o)
    else $error("late cycle not flagged");

  // valid only in phase 2
  // Valid may only stand while the synced second phase was seen low.
  a_valid_ph2 : assert property (@(posedge clk_i) disable iff (!nrst_i)
    data_valid_o |-> !$past(ph2_n))
    else $error("valid outside phase 2");

  c_ext_shift : cover property (@(posedge clk_i) disable iff (!nrst_i)
    shift_now && fifo_valid && fifo_data[1]);
  c_recirc_shift : cover property (@(posedge clk_i) disable iff (!nrst_i)
    shift_now && fifo_valid && !fifo_data[1]);
  c_wrap : cover property (@(posedge clk_i) disable iff (!nrst_i)
    shift_now && head_ff == AW'(DEPTH - 1));
endmodule
